// ### logic/arp_pkg.sv
// Operation
// - An auto-run channel setting picks the stored program run after power-on; -1 turns it off, 0 to 255 pick one.
// - The device stops at once while the emergency-stop input is off and runs only while it is on.
// - The emergency-stop input defaults to normally closed, so an open contact means stop.
// - While the hold input is active no further program command is carried out; normally closed makes open mean hold.
// - The normal-status output is closed while healthy and open on any alarm or warning.
// - The in-position output is closed only when positioning is done and the target is held.
// - The scale-division setting defaults to 360000 and accepts 1 to 2621440.
// - Incremental moves count user units and accept up to plus or minus 100 times the scale division.
// - A dwell command pauses the program for 0.1 to 10000.0 ms.
// - Auto-run and scale-division writes are taken only after the password has been given.
// - Each control input can be switched to normally closed contact polarity.
// - An unwired servo-on input set to normally closed reads as on, so the servo energises after power-on.
// - Software can reassign the function of every general input and output.
// - After the power-on delay the normal-status output settles and the auto-run channel starts, still obeying hold.
// - A jump command moves execution to the first line of channel 0 to 255.
package arp_pkg;
    localparam logic [7:0]  OFF_UNLOCK    = 8'h00;
    localparam logic [7:0]  OFF_AUTORUN   = 8'h04;
    localparam logic [7:0]  OFF_SCALE     = 8'h08;
    localparam logic [7:0]  OFF_PORTS     = 8'h0c;
    localparam logic [7:0]  OFF_STATUS    = 8'h10;
    localparam logic [7:0]  OFF_MASK      = 8'h14;
    localparam logic [7:0]  OFF_PADDR     = 8'h18;
    localparam logic [7:0]  OFF_PDATA     = 8'h1c;
    localparam logic [7:0]  OFF_RUN       = 8'h20;
    localparam logic [31:0] PASS_KEY      = 32'h5a5a_c3c3; // Arbitrary value.
    localparam logic [8:0]  AUTORUN_RST   = 9'h1ff;
    localparam logic [21:0] SCALE_RST     = 22'h057e40;
    localparam logic [21:0] SCALE_MIN     = 22'h000001;
    localparam logic [21:0] SCALE_MAX     = 22'h280000;
    localparam logic [28:0] MOVE_FACTOR   = 29'h0000064;
    localparam logic [29:0] DWELL_MIN     = 30'h00000001;
    localparam logic [29:0] DWELL_MAX     = 30'h000186a0;
    localparam logic [31:0] PORTS_RST     = 32'h0801_08d1;
    localparam int          IN_FN_W       = 3;
    localparam int          IN_POL_LSB    = 16;
    localparam int          OUT_FN_LSB    = 24;
    localparam int          OUT_FN_W      = 2;
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          TICK_NS       = 100000;
    localparam int          INIT_TIME_NS  = 10000000;
    localparam int          OP_LSB        = 30;
    localparam int          ARG_W         = 30;
    localparam int          STATUS_W      = 4;
    localparam int          ST_ESTOP      = 0;
    localparam int          ST_DONE       = 1;
    localparam int          ST_ALARM      = 2;
    localparam int          ST_REFUSE     = 3;
    localparam logic [1:0]  OP_END        = 2'h0;
    localparam logic [1:0]  OP_MOVE       = 2'h1;
    localparam logic [1:0]  OP_DWELL      = 2'h2;
    localparam logic [1:0]  OP_JUMP       = 2'h3;
    localparam logic [2:0]  FN_ESTOP      = 3'h1;
    localparam logic [2:0]  FN_HOLD       = 3'h2;
    localparam logic [2:0]  FN_SERVO      = 3'h3;
    localparam logic [2:0]  FN_HALT       = 3'h4;
    localparam logic [1:0]  OF_READY      = 2'h0;
    localparam logic [1:0]  OF_NORMAL     = 2'h1;
    localparam logic [1:0]  OF_INPOS      = 2'h2;
    localparam logic [1:0]  OF_BUSY       = 2'h3;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [6:0] {
        S_INIT  = 7'b0000001,
        S_IDLE  = 7'b0000010,
        S_FETCH = 7'b0000100,
        S_EXEC  = 7'b0001000,
        S_MOVE  = 7'b0010000,
        S_DWELL = 7'b0100000,
        S_STOP  = 7'b1000000
    } arp_state_e;
endpackage : arp_pkg

// ### logic/arp_prog_mem.sv
module arp_prog_mem #(
    parameter int W  = 32,
    parameter int AW = 10
) (
    // Clock.
    input  wire logic          clk,
    // Write side.
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [W-1:0]  wrData,
    // Read side.
    input  wire logic [AW-1:0] rdAddr,
    output logic      [W-1:0]  rdData
);
    logic [W-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : arp_prog_mem

// ### logic/arp_auto_run.sv
module arp_auto_run #(
    parameter int NIN      = 4,
    parameter int NOUT     = 2,
    parameter int LINE_W   = 2,
    parameter int INIT_CYC = arp_pkg::INIT_TIME_NS / arp_pkg::CLK_PERIOD_NS,
    parameter int TICK_CYC = arp_pkg::TICK_NS / arp_pkg::CLK_PERIOD_NS
) (
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // AXI4-Lite slave.
    input  wire logic [7:0]      awaddr,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    input  wire logic [7:0]      araddr,
    input  wire logic            arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  wire logic            rready,
    // Control connector, 1 means contact closed.
    input  wire logic [NIN-1:0]  ctrlIn,
    output logic      [NOUT-1:0] ctrlOut,
    // Servo side.
    input  wire logic            alarmIn,
    input  wire logic            warningIn,
    input  wire logic            posLostIn,
    input  wire logic            inTargetIn,
    input  wire logic            moveDone,
    output logic                 moveValid,
    output logic [arp_pkg::ARG_W-1:0] moveSteps,
    output logic [21:0]          scaleDiv,
    output logic                 servoOn,
    // Interrupt.
    output logic                 irq
);
    import arp_pkg::*;

    localparam int AW = 8 + LINE_W;
    localparam int IW = $clog2(INIT_CYC + 1);
    localparam int TW = $clog2(TICK_CYC + 1);

    arp_state_e            stateQ, stateD;
    logic [7:0]            chanQ, chanD;
    logic [LINE_W-1:0]     lineQ, lineD;
    logic [16:0]           dwellQ, dwellD;
    logic [TW-1:0]         tickQ;
    logic [IW-1:0]         initQ;
    logic [8:0]            autorunQ;
    logic [21:0]           scaleQ;
    logic [31:0]           portsQ;
    logic [STATUS_W-1:0]   statusQ, maskQ, events;
    logic [AW-1:0]         paddrQ;
    logic                  unlockQ, alarmQ, bvalidQ, rvalidQ;
    logic [1:0]            brespQ;
    logic [31:0]           rdataQ, memData, rdMux;
    logic [ARG_W-1:0]      stepsQ;
    logic [NOUT-1:0]       outQ;
    logic                  servoQ;
    logic                  doneEv, refuseEv, adv;

    // Write channel: address and data are taken together.
    wire        wrGo     = awvalid && wvalid && !bvalidQ;
    wire        wAutorun = awaddr == OFF_AUTORUN;
    wire        wScale   = awaddr == OFF_SCALE;
    wire        wProt    = wAutorun || wScale;
    wire        autoOk   = wdata == 32'hffff_ffff || wdata <= 32'h0000_00ff;
    wire        scaleOk  = wdata >= 32'(SCALE_MIN) && wdata <= 32'(SCALE_MAX);
    wire        wMapped  = wProt || awaddr == OFF_UNLOCK || awaddr == OFF_PORTS || awaddr == OFF_STATUS
                           || awaddr == OFF_MASK || awaddr == OFF_PADDR || awaddr == OFF_PDATA || awaddr == OFF_RUN;
    wire        wBad     = !wMapped || wstrb != 4'hf || (wProt && !unlockQ)
                           || (wAutorun && !autoOk) || (wScale && !scaleOk);
    wire        wOk      = wrGo && !wBad;
    wire        runWr    = wOk && awaddr == OFF_RUN;
    wire        memWr    = wOk && awaddr == OFF_PDATA;
    wire        rdGo     = arvalid && !rvalidQ;

    assign awready = wrGo;
    assign wready  = wrGo;
    assign bvalid  = bvalidQ;
    assign bresp   = brespQ;
    assign arready = !rvalidQ;
    assign rvalid  = rvalidQ;
    assign rdata   = rdataQ;
    assign rresp   = RESP_OKAY;

    // Per-input polarity and function decode.
    logic [NIN-1:0] asserted, estopHit, holdHit, servoHit, haltHit;
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in
            wire [IN_FN_W-1:0] fn = portsQ[gi*IN_FN_W +: IN_FN_W];
            assign asserted[gi] = portsQ[IN_POL_LSB+gi] ? !ctrlIn[gi] : ctrlIn[gi];
            assign estopHit[gi] = asserted[gi] && fn == FN_ESTOP;
            assign holdHit[gi]  = asserted[gi] && fn == FN_HOLD;
            assign servoHit[gi] = asserted[gi] && fn == FN_SERVO;
            assign haltHit[gi]  = asserted[gi] && fn == FN_HALT;
        end
    endgenerate

    wire estopNow = |estopHit;
    wire holdNow  = |holdHit;
    wire haltNow  = |haltHit;
    wire initDone = stateQ != S_INIT;

    // Program decode.
    wire [1:0]       op       = memData[OP_LSB +: 2];
    wire [ARG_W-1:0] arg      = memData[ARG_W-1:0];
    wire [ARG_W-1:0] absSteps = arg[ARG_W-1] ? ARG_W'(-arg) : arg;
    wire [28:0]      limit    = 29'(scaleQ) * MOVE_FACTOR;
    wire             moveOk   = absSteps <= {1'b0, limit};
    wire             dwellOk  = arg >= DWELL_MIN && arg <= DWELL_MAX;
    wire             lastLine = lineQ == LINE_W'((2 ** LINE_W) - 1);
    wire             tick     = tickQ == TW'(TICK_CYC - 1);
    wire             initEnd  = initQ == IW'(INIT_CYC - 1);

    arp_prog_mem #(.W(32), .AW(AW)) u_mem (
        .clk    (clk),
        .wrEn   (memWr),
        .wrAddr (paddrQ),
        .wrData (wdata),
        .rdAddr ({chanQ, lineQ}),
        .rdData (memData)
    );

    always_comb begin
        stateD   = stateQ;
        chanD    = chanQ;
        lineD    = lineQ;
        dwellD   = dwellQ;
        doneEv   = 1'b0;
        refuseEv = 1'b0;
        adv      = 1'b0;
        unique case (stateQ)
            S_INIT: begin
                if (initEnd) begin
                    if (alarmQ) begin
                        stateD = S_STOP;
                    end else if (!autorunQ[8]) begin
                        stateD = S_FETCH;
                        chanD  = autorunQ[7:0];
                        lineD  = '0;
                    end else begin
                        stateD = S_IDLE;
                    end
                end
            end
            S_IDLE: begin
                if (runWr) begin
                    stateD = S_FETCH;
                    chanD  = wdata[7:0];
                    lineD  = '0;
                end
            end
            S_FETCH: stateD = S_EXEC;
            S_EXEC: begin
                if (!holdNow) begin
                    unique case (op)
                        OP_END: begin
                            stateD = S_IDLE;
                            doneEv = 1'b1;
                        end
                        OP_MOVE: begin
                            stateD   = moveOk ? S_MOVE : S_EXEC;
                            refuseEv = !moveOk;
                            adv      = !moveOk;
                        end
                        OP_DWELL: begin
                            stateD   = dwellOk ? S_DWELL : S_EXEC;
                            dwellD   = arg[16:0];
                            refuseEv = !dwellOk;
                            adv      = !dwellOk;
                        end
                        OP_JUMP: begin
                            stateD = S_FETCH;
                            chanD  = arg[7:0];
                            lineD  = '0;
                        end
                    endcase
                end
            end
            S_MOVE: adv = moveDone;
            S_DWELL: begin
                if (!holdNow && tick) begin
                    adv    = dwellQ == 17'h00001;
                    dwellD = dwellQ - 17'h00001;
                end
            end
            S_STOP: stateD = S_STOP;
        endcase
        if (adv) begin
            stateD = lastLine ? S_IDLE : S_FETCH;
            lineD  = lineQ + LINE_W'(1);
            doneEv = lastLine;
        end
        if (initDone && stateQ != S_STOP) begin
            if (estopNow || alarmIn) begin
                stateD = S_STOP;
            end else if (haltNow && stateQ != S_IDLE) begin
                stateD = S_IDLE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateQ <= S_INIT;
            chanQ  <= '0;
            lineQ  <= '0;
            dwellQ <= '0;
            stepsQ <= '0;
        end else begin
            stateQ <= stateD;
            chanQ  <= chanD;
            lineQ  <= lineD;
            dwellQ <= dwellD;
            if (stateQ == S_EXEC && stateD == S_MOVE) begin
                stepsQ <= arg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            initQ  <= '0;
            tickQ  <= '0;
            alarmQ <= 1'b0;
        end else begin
            initQ  <= initDone ? initQ : initQ + IW'(1);
            tickQ  <= (stateQ != S_DWELL || tick) ? '0 : tickQ + TW'(!holdNow);
            alarmQ <= alarmQ || alarmIn || (initDone && estopNow);
        end
    end

    assign events = {refuseEv, alarmIn, doneEv, initDone && estopNow && !alarmQ};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            autorunQ <= AUTORUN_RST;
            scaleQ   <= SCALE_RST;
            portsQ   <= PORTS_RST;
            maskQ    <= '0;
            statusQ  <= '0;
            paddrQ   <= '0;
            unlockQ  <= 1'b0;
        end else begin
            statusQ <= (statusQ & ~((wOk && awaddr == OFF_STATUS) ? wdata[STATUS_W-1:0] : '0)) | events;
            if (wOk && wAutorun) autorunQ <= wdata[8:0];
            if (wOk && wScale) scaleQ <= wdata[21:0];
            if (wOk && awaddr == OFF_PORTS) portsQ <= wdata;
            if (wOk && awaddr == OFF_MASK) maskQ <= wdata[STATUS_W-1:0];
            if (wOk && awaddr == OFF_PADDR) paddrQ <= wdata[AW-1:0];
            if (memWr) paddrQ <= paddrQ + AW'(1);
            if (wrGo && (awaddr == OFF_UNLOCK || wProt)) unlockQ <= awaddr == OFF_UNLOCK && wdata == PASS_KEY;
        end
    end

    assign rdMux = araddr == OFF_AUTORUN ? {{23{autorunQ[8]}}, autorunQ}
                 : araddr == OFF_SCALE   ? 32'(scaleQ)
                 : araddr == OFF_PORTS   ? portsQ
                 : araddr == OFF_STATUS  ? 32'(statusQ)
                 : araddr == OFF_MASK    ? 32'(maskQ)
                 : araddr == OFF_PADDR   ? 32'(paddrQ)
                 : araddr == OFF_RUN     ? {1'b0, stateQ, 4'h0, unlockQ, servoQ, holdNow, alarmQ,
                                            2'h0, 6'(lineQ), chanQ}
                 : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalidQ <= 1'b0;
            brespQ  <= RESP_OKAY;
            rvalidQ <= 1'b0;
            rdataQ  <= '0;
        end else begin
            bvalidQ <= wrGo || (bvalidQ && !bready);
            if (wrGo) brespQ <= wBad ? RESP_SLVERR : RESP_OKAY;
            rvalidQ <= rdGo || (rvalidQ && !rready);
            if (rdGo) rdataQ <= rdMux;
        end
    end

    // Status outputs, each routed by its port function.
    wire normalNow = initDone && !alarmQ && !warningIn;
    wire inPosNow  = initDone && inTargetIn && !posLostIn && stateQ != S_MOVE;
    wire busyNow   = stateQ != S_INIT && stateQ != S_IDLE && stateQ != S_STOP;
    genvar go;
    generate
        for (go = 0; go < NOUT; go++) begin : g_out
            wire [OUT_FN_W-1:0] fn = portsQ[OUT_FN_LSB + go*OUT_FN_W +: OUT_FN_W];
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    outQ[go] <= 1'b0;
                end else begin
                    outQ[go] <= fn == OF_NORMAL ? normalNow : fn == OF_INPOS ? inPosNow
                              : fn == OF_BUSY ? busyNow : initDone && !alarmQ;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            servoQ <= 1'b0;
        end else begin
            servoQ <= initDone && !alarmQ && |servoHit;
        end
    end

    assign ctrlOut   = outQ;
    assign servoOn   = servoQ;
    assign moveValid = stateQ == S_MOVE;
    assign moveSteps = stepsQ;
    assign scaleDiv  = scaleQ;
    assign irq       = |(statusQ & maskQ);

    property p_autorun;
        @(posedge clk) disable iff (sys_rst)
        stateQ == S_INIT && initEnd && !alarmQ && !autorunQ[8] |=> stateQ == S_FETCH && chanQ == $past(autorunQ[7:0]);
    endproperty
    a_autorun: assert property (p_autorun) else $error("auto-run channel not started");

    property p_estop;
        @(posedge clk) disable iff (sys_rst)
        initDone && estopNow |=> stateQ == S_STOP ##1 stateQ == S_STOP && !moveValid;
    endproperty
    a_estop: assert property (p_estop) else $error("emergency stop not taken");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        stateQ == S_EXEC && holdNow && !estopNow && !haltNow && !alarmIn |=> stateQ == S_EXEC && $stable(lineQ);
    endproperty
    a_hold: assert property (p_hold) else $error("command run during hold");

    property p_normal;
        @(posedge clk) disable iff (sys_rst)
        (alarmQ || warningIn) && portsQ[OUT_FN_LSB +: OUT_FN_W] == OF_NORMAL |=> !ctrlOut[0];
    endproperty
    a_normal: assert property (p_normal) else $error("normal output closed during fault");

    property p_inpos;
        @(posedge clk) disable iff (sys_rst)
        (posLostIn || moveValid) && portsQ[OUT_FN_LSB + OUT_FN_W +: OUT_FN_W] == OF_INPOS |=> !ctrlOut[1];
    endproperty
    a_inpos: assert property (p_inpos) else $error("in-position closed while not held");

    property p_scale;
        @(posedge clk) disable iff (sys_rst)
        scaleQ >= SCALE_MIN && scaleQ <= SCALE_MAX;
    endproperty
    a_scale: assert property (p_scale) else $error("scale division out of range");

    property p_locked;
        @(posedge clk) disable iff (sys_rst)
        wrGo && wProt && !unlockQ |=> $stable(autorunQ) && $stable(scaleQ) && bresp == RESP_SLVERR && !unlockQ;
    endproperty
    a_locked: assert property (p_locked) else $error("protected write taken without password");

    property p_jump;
        @(posedge clk) disable iff (sys_rst)
        stateQ == S_EXEC && op == OP_JUMP && !holdNow && !estopNow && !haltNow && !alarmIn
        |=> stateQ == S_FETCH && lineQ == '0 ##1 stateQ == S_EXEC;
    endproperty
    a_jump: assert property (p_jump) else $error("jump did not reach first line");

    property p_move_wait;
        @(posedge clk) disable iff (sys_rst)
        moveValid && !moveDone && !estopNow && !haltNow && !alarmIn |=> moveValid && $stable(moveSteps) && $stable(lineQ);
    endproperty
    a_move_wait: assert property (p_move_wait) else $error("next line began before move finished");

    property p_servo;
        @(posedge clk) disable iff (sys_rst)
        initDone && !alarmQ && |servoHit |=> servoOn;
    endproperty
    a_servo: assert property (p_servo) else $error("servo not energised");

    c_autorun: cover property (@(posedge clk) disable iff (sys_rst) stateQ == S_INIT ##1 stateQ == S_FETCH);
    c_dwell:   cover property (@(posedge clk) disable iff (sys_rst) stateQ == S_DWELL ##1 stateQ == S_FETCH);
    c_jump:    cover property (@(posedge clk) disable iff (sys_rst) stateQ == S_EXEC && op == OP_JUMP && !holdNow);
    c_estop:   cover property (@(posedge clk) disable iff (sys_rst) stateQ == S_MOVE ##1 stateQ == S_STOP);
endmodule : arp_auto_run

// ### test/arp_host_model.sv
module arp_host_model (
    // Clock.
    input  wire logic       clk,
    // Bench controls.
    input  wire logic       estopOn,
    input  wire logic       holdOn,
    input  wire logic [3:0] lag,
    // Servo handshake.
    input  wire logic       moveValid,
    output logic            moveDone,
    output logic            inTarget,
    // Contacts, 1 means closed.
    output logic      [3:0] ctrlIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt = 5'h0;
    // Stop contact is wired normally closed; servo-on and halt stay unwired, so open.
    assign ctrlIn   = {2'b00, holdOn, !estopOn};
    assign inTarget = !moveValid;
    // A move finishes lag+1 cycles after it is offered, then the count parks.
    always @(posedge clk) begin
        moveDone <= moveValid && cnt == {1'b0, lag};
        cnt      <= !moveValid ? 5'h0 : (cnt > {1'b0, lag} ? cnt : cnt + 5'h1);
    end
endmodule : arp_host_model

// ### test/test_auto_run_program_io.sv
module test_auto_run_program_io;
    timeunit 1ns;
    timeprecision 1ps;
    import arp_pkg::*;
    logic clk = 0, sysRst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic warn = 0, estopOn = 0, holdOn = 0, alm = 0, lost = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] lag = 4'h2;
    wire awready, wready, bvalid, arready, rvalid, moveValid, moveDone, inTarget, servoOn, irq;
    wire [1:0] bresp, rresp, ctrlOut;
    wire [31:0] rdata;
    wire [3:0] ctrlIn;
    wire [29:0] moveSteps;
    wire [21:0] scaleDiv;
    int fails = 0, comparisons = 0, cyc = 0, seed = 74455, n, s;
    logic [1:0] expB[$];
    logic [31:0] expR[$];
    logic [31:0] prog[6];
    arp_auto_run #(.INIT_CYC(20), .TICK_CYC(4)) arp_auto_run_inst (.clk(clk), .sys_rst(sysRst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ctrlIn(ctrlIn), .ctrlOut(ctrlOut), .alarmIn(alm), .warningIn(warn), .posLostIn(lost),
        .inTargetIn(inTarget), .moveDone(moveDone), .moveValid(moveValid), .moveSteps(moveSteps),
        .scaleDiv(scaleDiv), .servoOn(servoOn), .irq(irq));
    arp_host_model arp_host_model_inst (.clk(clk), .estopOn(estopOn), .holdOn(holdOn), .lag(lag),
        .moveValid(moveValid), .moveDone(moveDone), .inTarget(inTarget), .ctrlIn(ctrlIn));
    initial forever #10 clk = ~clk;
    task end_sim;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        expB.push_back(e);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
        awvalid <= 0; wvalid <= 0;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 0;
        @(posedge clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        expR.push_back(e);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 0;
        @(posedge clk);
    endtask : rd
    task waitMv(input logic lvl);
        n = 0;
        while (moveValid !== lvl && n < 400) begin
            @(posedge clk); n++;
        end
    endtask : waitMv
    always @(posedge clk) begin
        if (bvalid && bready) chk({30'h0, bresp}, {30'h0, expB.pop_front()});
        if (rvalid && rready) chk(rdata, expR.pop_front());
        if (rvalid && rready) chk({30'h0, rresp}, {30'h0, RESP_OKAY});
        if (++cyc == 20000) begin
            fails++; end_sim();
        end
    end
    initial begin
        s = $random(seed) % 1000;
        lag <= 4'($random(seed));
        prog = '{{OP_MOVE, 30'(s)}, {OP_DWELL, 30'h2}, {OP_MOVE, 30'h3}, {OP_JUMP, 30'h2},
                 {OP_MOVE, 30'h7}, {OP_END, 30'h0}};
        repeat (8) @(posedge clk);
        sysRst <= 0;
        repeat (25) @(posedge clk);
        rd(OFF_AUTORUN, 32'hffff_ffff);
        rd(OFF_SCALE, {10'h0, SCALE_RST});
        wr(OFF_SCALE, 32'h4, RESP_SLVERR);
        wr(OFF_UNLOCK, PASS_KEY, RESP_OKAY);
        wr(OFF_SCALE, 32'h0, RESP_SLVERR);
        wr(OFF_UNLOCK, PASS_KEY, RESP_OKAY);
        wr(OFF_SCALE, {10'h0, SCALE_MAX}, RESP_OKAY);
        chk({10'h0, scaleDiv}, {10'h0, SCALE_MAX});
        wr(OFF_UNLOCK, PASS_KEY, RESP_OKAY);
        wr(OFF_AUTORUN, 32'h100, RESP_SLVERR);
        wr(OFF_UNLOCK, PASS_KEY, RESP_OKAY);
        wr(OFF_AUTORUN, 32'hff, RESP_OKAY);
        rd(OFF_AUTORUN, 32'hff);
        wr(8'h40, 32'h1, RESP_SLVERR);
        rd(8'h40, 32'h0);
        wr(OFF_PORTS, 32'h0905_08d1, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk(servoOn, 1);
        chk(ctrlOut[0], 1);
        warn <= 1;
        repeat (3) @(posedge clk);
        chk(ctrlOut[0], 0);
        warn <= 0;
        wr(OFF_PADDR, 32'h4, RESP_OKAY);
        for (int i = 0; i < 6; i++) wr(OFF_PDATA, prog[i], RESP_OKAY);
        holdOn <= 1;
        wr(OFF_RUN, 32'h1, RESP_OKAY);
        repeat (30) @(posedge clk);
        chk(moveValid, 0);
        holdOn <= 0;
        waitMv(1);
        chk({2'b0, moveSteps}, {2'b0, 30'(s)});
        waitMv(0);
        waitMv(1);
        chk(n >= 8, 1);
        chk({2'b0, moveSteps}, 32'h3);
        waitMv(0);
        waitMv(1);
        chk({2'b0, moveSteps}, 32'h7);
        waitMv(0);
        repeat (10) @(posedge clk);
        chk(ctrlOut[1], 1);
        lost <= 1;
        repeat (3) @(posedge clk);
        chk(ctrlOut[1], 0);
        lost <= 0;
        wr(OFF_MASK, 32'h2, RESP_OKAY);
        chk(irq, 1);
        wr(OFF_MASK, 32'h0, RESP_OKAY);
        chk(irq, 0);
        wr(OFF_MASK, 32'h3, RESP_OKAY);
        wr(OFF_STATUS, 32'h2, RESP_OKAY);
        chk(irq, 0);
        estopOn <= 1;
        repeat (3) @(posedge clk);
        chk(irq, 1);
        rd(OFF_STATUS, 32'h1);
        rd(OFF_RUN, 32'h4001_0102);
        sysRst <= 1;
        estopOn <= 0;
        repeat (8) @(posedge clk);
        sysRst <= 0;
        wr(OFF_UNLOCK, PASS_KEY, RESP_OKAY);
        wr(OFF_AUTORUN, 32'h1, RESP_OKAY);
        waitMv(1);
        chk(moveValid, 1);
        chk({2'b0, moveSteps}, {2'b0, 30'(s)});
        alm <= 1;
        repeat (3) @(posedge clk);
        chk(moveValid, 0);
        rd(OFF_STATUS, 32'h4);
        end_sim();
    end
endmodule : test_auto_run_program_io
